// ===== logic/tmas_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmas_regs.svh"

module tmas_top #(
  parameter logic [6:0] DEV_ADDR = `TMAS_DEV_ADDR,
  parameter int unsigned CONV_CYC = `TMAS_CONV_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic scl_clk,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  output logic alert_o,
  output logic alert_oe,
  input wire logic standby_pin_n,
  input wire logic remote_open,
  input wire logic adc_done,
  input wire logic [7:0] adc_local,
  input wire logic [10:0] adc_remote,
  input wire logic adc_under,
  output logic adc_start,
  output logic adc_abort
);

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n || !ce);

  // ==================================================================
  // Serial bus side.
  tmas_pkg::tmas_regs_t regs_link, regs_r;
  tmas_pkg::tmas_snap_t snap;
  logic [2:0] ev_tg;
  logic alert_r, snap_tg_r, snap_req;
  tmas_pkg::tmas_snap_t snap_pub_r;

  tmas_link #(
    .DEV_ADDR(DEV_ADDR)
  ) u_link (
    .scl_clk(scl_clk),
    .rst_n(rst_n),
    .sda_i(sda_i),
    .sda_oe(sda_oe),
    .alert_act(alert_r),
    .snap(snap),
    .snap_tg(snap_tg_r),
    .snap_req(snap_req),
    .regs(regs_link),
    .ev_tg(ev_tg)
  );

  // ==================================================================
  // Synchronisers for pins and bus events.
  wire logic [5:0] async_in = {snap_req, remote_open, standby_pin_n, ev_tg};
  logic [5:0] s1_r, s2_r, s3_r;

  // Each input passes two flops; a third flop gives event edges.
  for (genvar i = 0; i < 6; i++) begin : g_sync
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        s1_r[i] <= 1'b0;
        s2_r[i] <= 1'b0;
        s3_r[i] <= 1'b0;
      end else if (ce) begin
        s1_r[i] <= async_in[i];
        s2_r[i] <= s1_r[i];
        s3_r[i] <= s2_r[i];
      end
    end
  end

  // Named views of the synchronised inputs.
  wire logic [2:0] ev = s2_r[2:0] ^ s3_r[2:0];
  wire logic wr_ev = ev[0];
  wire logic os_ev = ev[1];
  wire logic ara_ev = ev[2];
  wire logic pin_high = s2_r[3];
  wire logic open_s = s2_r[4];
  wire logic snap_ask = s2_r[5] != snap_tg_r;

  // Written registers are copied once their toggle has settled.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regs_r <= '{`TMAS_CFG_RST, `TMAS_HI_RST, `TMAS_LO_RST, `TMAS_HI_RST, `TMAS_LO_RST};
    end else if (ce && wr_ev) begin
      regs_r <= regs_link;
    end
  end

  // ==================================================================
  // Standby and conversion sequencing.
  tmas_pkg::tmas_state_t st_r, st_nxt;
  logic [13:0] tmr_r;
  logic os_pend_r, os_run_r, adc_start_r, adc_abort_r;
  logic [7:0] stat_r, ltemp_r;
  logic [10:0] rtemp_r;
  logic cond_r;

  wire logic cfg_sb = regs_r.cfg[`TMAS_CFG_STANDBY_PIN_N];
  wire logic standby = !pin_high || cfg_sb;
  wire logic st_idle = st_r == tmas_pkg::ST_IDLE;
  wire logic st_conv = st_r == tmas_pkg::ST_CONV;
  wire logic st_cmp = st_r == tmas_pkg::ST_CMP;
  wire logic tmr_done = tmr_r == 14'(CONV_CYC - 1);
  wire logic go = st_idle && pin_high && (os_pend_r || (!standby && tmr_done));
  wire logic abort = st_conv && (!pin_high || (cfg_sb && !os_run_r));
  wire logic take = st_conv && !abort && adc_done;

  // Sequencer transitions.
  always_comb begin
    st_nxt = st_r;
    unique case (st_r)
      tmas_pkg::ST_IDLE: if (go) begin
        st_nxt = tmas_pkg::ST_CONV;
      end
      tmas_pkg::ST_CONV: if (abort) begin
        st_nxt = tmas_pkg::ST_IDLE;
      end else if (adc_done) begin
        st_nxt = tmas_pkg::ST_CMP;
      end
      tmas_pkg::ST_CMP: st_nxt = tmas_pkg::ST_IDLE;
      default: st_nxt = tmas_pkg::ST_IDLE;
    endcase
  end

  // Interval timer runs only while idle and out of standby.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tmr_r <= 14'h0000;
    end else if (ce) begin
      tmr_r <= (!st_idle || standby || tmr_done) ? 14'h0000 : tmr_r + 14'h0001;
    end
  end

  // State, one-shot request and converter strobes.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= tmas_pkg::ST_IDLE;
      os_pend_r <= 1'b0;
      os_run_r <= 1'b0;
      adc_start_r <= 1'b0;
      adc_abort_r <= 1'b0;
    end else if (ce) begin
      st_r <= st_nxt;
      adc_start_r <= go;
      adc_abort_r <= abort;
      os_pend_r <= pin_high && !go && (os_pend_r || (os_ev && cfg_sb));
      if (go) begin
        os_run_r <= os_pend_r;
      end
    end
  end

  // ==================================================================
  // Results and limit comparison.
  // strict comparisons
  wire logic lhi_f = $signed(ltemp_r) > $signed(regs_r.lhi);
  wire logic llo_f = $signed(ltemp_r) < $signed(regs_r.llo);
  wire logic rhi_f = $signed(rtemp_r[10:3]) > $signed(regs_r.rhi);
  wire logic rlo_f = $signed(rtemp_r[10:3]) < $signed(regs_r.rlo);
  wire logic hit = lhi_f || llo_f || rhi_f || rlo_f || stat_r[`TMAS_ST_OPEN];

  // Results other than the open flag, sampled at each start, update only on a completed conversion.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ltemp_r <= 8'h00;
      rtemp_r <= 11'h000;
      stat_r <= 8'h00;
      cond_r <= 1'b0;
    end else if (ce) begin
      if (take) begin
        ltemp_r <= adc_local;
        rtemp_r <= adc_under ? `TMAS_SHORT_CODE : adc_remote;
      end
      if (go) begin
        stat_r[`TMAS_ST_OPEN] <= open_s;
      end
      if (st_cmp) begin
        stat_r[`TMAS_ST_LHI] <= lhi_f;
        stat_r[`TMAS_ST_LLO] <= llo_f;
        stat_r[`TMAS_ST_RHI] <= rhi_f;
        stat_r[`TMAS_ST_RLO] <= rlo_f;
        cond_r <= hit;
      end
    end
  end

  // ==================================================================
  // Alert and result publication.
  // Results are frozen into the published copy when the bus side asks; the answer toggles back.
  // The copy stands still between answers, so the bus side never reads a half-updated word.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      snap_pub_r <= '0;
      snap_tg_r <= 1'b0;
    end else if (ce && snap_ask) begin
      snap_pub_r <= '{stat_r, ltemp_r, rtemp_r};
      snap_tg_r <= s2_r[5];
    end
  end

  assign snap = snap_pub_r;

  // A new condition wins over a release in the same cycle.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      alert_r <= 1'b0;
    end else if (ce) begin
      if (st_cmp && hit) begin
        alert_r <= 1'b1;
      end else if (ara_ev && !cond_r) begin
        alert_r <= 1'b0;
      end
    end
  end

  assign alert_o = 1'b0;
  assign alert_oe = alert_r;
  assign sda_o = 1'b0;
  assign adc_start = adc_start_r;
  assign adc_abort = adc_abort_r;

  // ==================================================================
  // Checks.
  sequence s_cmp_standby_pin_n;
    st_cmp && standby && !os_pend_r && !os_ev;
  endsequence

  sequence s_rest_idle;
    st_idle && !adc_start_r ##1 !adc_start_r;
  endsequence

  a_alert_set: assert property (st_cmp && hit |=> alert_oe && !alert_o)
    else $error("alert not asserted on fault");

  a_alert_keep: assert property (alert_r && cond_r && !st_cmp |=> alert_r)
    else $error("alert released while condition held");

  a_alert_rel: assert property (ara_ev && !cond_r && !st_cmp |=> !alert_oe)
    else $error("alert not released after reply");

  a_standby_pin_n_idle: assert property (st_idle && standby && !os_pend_r |=> !adc_start_r)
    else $error("conversion started in standby");

  a_abort_cnv: assert property (st_conv && !pin_high |=> adc_abort && st_idle)
    else $error("standby did not abort conversion");

  a_no_update: assert property (abort |=> $stable(rtemp_r) && $stable(ltemp_r))
    else $error("aborted conversion updated result");

  a_pin_block: assert property (!pin_high |=> !adc_start_r && !st_conv)
    else $error("conversion while standby pin low");

  a_one_shot: assert property (os_ev && cfg_sb && pin_high && st_idle
    ##1 pin_high |-> ##1 adc_start_r)
    else $error("one-shot did not start conversion");

  a_open_flag: assert property (go |=> stat_r[`TMAS_ST_OPEN] == $past(open_s))
    else $error("open flag not sampled at start");

  a_short_code: assert property (take && adc_under |=> rtemp_r == `TMAS_SHORT_CODE)
    else $error("short not reported as minus 128");

  a_high_strict: assert property (st_cmp && ltemp_r == regs_r.lhi |=> !stat_r[`TMAS_ST_LHI])
    else $error("equal reading flagged as high");

  a_one_shot_end: assert property (s_cmp_standby_pin_n |=> s_rest_idle)
    else $error("conversion continued after one-shot");

  a_snap_hold: assert property (!snap_ask |=> $stable(snap_pub_r))
    else $error("published results changed without request");

endmodule

`default_nettype wire

// ===== logic/tmas_regs.svh
`ifndef TMAS_REGS_SVH
`define TMAS_REGS_SVH

// ====================================================================
// Register pointers for reads.
`define TMAS_RD_LTEMP 8'h00
`define TMAS_RD_RTEMP 8'h01
`define TMAS_RD_STAT 8'h02
`define TMAS_RD_CFG 8'h03
`define TMAS_RD_LHI 8'h05
`define TMAS_RD_LLO 8'h06
`define TMAS_RD_RHI 8'h07
`define TMAS_RD_RLO 8'h08
`define TMAS_RD_RFRAC 8'h10

// ====================================================================
// Register pointers for writes.
`define TMAS_WR_CFG 8'h09
`define TMAS_WR_LHI 8'h0B
`define TMAS_WR_LLO 8'h0C
`define TMAS_WR_RHI 8'h0D
`define TMAS_WR_RLO 8'h0E
`define TMAS_WR_ONESHOT 8'h0F

// ====================================================================
// Field positions.
`define TMAS_CFG_STANDBY_PIN_N 6
`define TMAS_ST_LHI 6
`define TMAS_ST_LLO 5
`define TMAS_ST_RHI 4
`define TMAS_ST_RLO 3
`define TMAS_ST_OPEN 2

// ====================================================================
// Reset values and fixed codes.
`define TMAS_CFG_RST 8'h00
`define TMAS_HI_RST 8'h7F
`define TMAS_LO_RST 8'h80
`define TMAS_SHORT_CODE 11'h400
`define TMAS_ARA 7'h0C
`define TMAS_DEV_ADDR 7'h18

// ====================================================================
// Timing.
`define TMAS_MCLK_MHZ 10
`define TMAS_CONV_US 1000
`define TMAS_CONV_CYC (`TMAS_CONV_US * `TMAS_MCLK_MHZ)

`endif

// ===== logic/tmas_pkg.sv
`default_nettype none

package tmas_pkg;

  // Registers written over the serial bus.
  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] lhi;
    logic [7:0] llo;
    logic [7:0] rhi;
    logic [7:0] rlo;
  } tmas_regs_t;

  // Results published to the serial bus side.
  typedef struct packed {
    logic [7:0] stat;
    logic [7:0] ltemp;
    logic [10:0] rtemp;
  } tmas_snap_t;

  // Conversion sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'h1,
    ST_CONV = 3'h2,
    ST_CMP = 3'h4
  } tmas_state_t;

  // Serial bus slave phases.
  typedef enum logic [6:0] {
    PH_IDLE = 7'h01,
    PH_ADDR = 7'h02,
    PH_ACKA = 7'h04,
    PH_WDAT = 7'h08,
    PH_ACKW = 7'h10,
    PH_RDAT = 7'h20,
    PH_ACKR = 7'h40
  } tmas_phase_t;

endpackage

`default_nettype wire

// ===== logic/tmas_link.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmas_regs.svh"

module tmas_link #(
  parameter logic [6:0] DEV_ADDR = `TMAS_DEV_ADDR
) (
  input wire logic scl_clk,
  input wire logic rst_n,
  input wire logic sda_i,
  output logic sda_oe,
  input wire logic alert_act,
  input wire tmas_pkg::tmas_snap_t snap,
  input wire logic snap_tg,
  output logic snap_req,
  output tmas_pkg::tmas_regs_t regs,
  output logic [2:0] ev_tg
);

  // ==================================================================
  // Start detection.
  logic start_tg_r, start_seen_r;

  // A falling data edge while the clock is high marks a start.
  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      start_tg_r <= 1'b0;
    end else if (scl_clk) begin
      start_tg_r <= ~start_tg_r;
    end
  end

  // ==================================================================
  // Crossings into the bus clock.
  logic [1:0] alert_sync_r, ack_sync_r;
  logic req_r;
  tmas_pkg::tmas_snap_t snap_r;

  // Results are copied once the system side has answered the last request, which is then renewed.
  // The system side holds its copy still until the next request, so no copy is torn and none is lost.
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert_sync_r <= 2'h0;
      ack_sync_r <= 2'h0;
      req_r <= 1'b0;
      snap_r <= '0;
    end else begin
      alert_sync_r <= {alert_sync_r[0], alert_act};
      ack_sync_r <= {ack_sync_r[0], snap_tg};
      if (ack_sync_r[1] == req_r) begin
        snap_r <= snap;
        req_r <= ~req_r;
      end
    end
  end

  assign snap_req = req_r;

  // ==================================================================
  // Bit engine.
  tmas_pkg::tmas_phase_t ph_r, ph_nxt;
  logic [2:0] cnt_r;
  logic [7:0] sh_r, tx_r, ptr_r;
  logic rw_r, ara_r, first_r, sda_oe_r;

  // Decoding of the byte being shifted in.
  wire logic start_pend = start_tg_r != start_seen_r;
  wire logic [7:0] byte_in = {sh_r[6:0], sda_i};
  wire logic last_bit = cnt_r == 3'h7;
  wire logic addr_me = byte_in[7:1] == DEV_ADDR;
  wire logic addr_ara = byte_in[7:1] == `TMAS_ARA && byte_in[0] && alert_sync_r[1];
  wire logic lost = tx_r[7] && !sda_i;
  wire logic shifting = ph_r == tmas_pkg::PH_ADDR || ph_r == tmas_pkg::PH_WDAT || ph_r == tmas_pkg::PH_RDAT;
  wire logic reg_wr = ph_r == tmas_pkg::PH_WDAT && last_bit && !start_pend;
  wire logic [2:0] cnt_nxt = start_pend ? 3'h1 : shifting ? cnt_r + 3'h1 : cnt_r;
  wire logic drive = ph_r == tmas_pkg::PH_ACKA || ph_r == tmas_pkg::PH_ACKW
                     || (ph_r == tmas_pkg::PH_RDAT && !tx_r[7]);

  // Read data selected by the pointer.
  function automatic logic [7:0] rd_mux(input logic [7:0] p);
    case (p)
      `TMAS_RD_LTEMP: rd_mux = snap_r.ltemp;
      `TMAS_RD_RTEMP: rd_mux = snap_r.rtemp[10:3];
      `TMAS_RD_RFRAC: rd_mux = {snap_r.rtemp[2:0], 5'h00};
      `TMAS_RD_STAT: rd_mux = snap_r.stat;
      `TMAS_RD_CFG: rd_mux = regs.cfg;
      `TMAS_RD_LHI: rd_mux = regs.lhi;
      `TMAS_RD_LLO: rd_mux = regs.llo;
      `TMAS_RD_RHI: rd_mux = regs.rhi;
      `TMAS_RD_RLO: rd_mux = regs.rlo;
      default: rd_mux = 8'h00;
    endcase
  endfunction

  // Phase sequencing; a start restarts the frame from any phase.
  always_comb begin
    ph_nxt = ph_r;
    unique case (ph_r)
      tmas_pkg::PH_IDLE: ph_nxt = tmas_pkg::PH_IDLE;
      tmas_pkg::PH_ADDR: if (last_bit) begin
        ph_nxt = (addr_me || addr_ara) ? tmas_pkg::PH_ACKA : tmas_pkg::PH_IDLE;
      end
      tmas_pkg::PH_ACKA: ph_nxt = rw_r ? tmas_pkg::PH_RDAT : tmas_pkg::PH_WDAT;
      tmas_pkg::PH_WDAT: if (last_bit) begin
        ph_nxt = tmas_pkg::PH_ACKW;
      end
      tmas_pkg::PH_ACKW: ph_nxt = tmas_pkg::PH_WDAT;
      tmas_pkg::PH_RDAT: if (lost) begin
        ph_nxt = tmas_pkg::PH_IDLE;
      end else if (last_bit) begin
        ph_nxt = tmas_pkg::PH_ACKR;
      end
      tmas_pkg::PH_ACKR: ph_nxt = tmas_pkg::PH_IDLE;
      default: ph_nxt = tmas_pkg::PH_IDLE;
    endcase
    if (start_pend) begin
      ph_nxt = tmas_pkg::PH_ADDR;
    end
  end

  // Sampling on the rising clock edge.
  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      ph_r <= tmas_pkg::PH_IDLE;
      start_seen_r <= 1'b0;
      cnt_r <= 3'h0;
      sh_r <= 8'h00;
      tx_r <= 8'hFF;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      ara_r <= 1'b0;
      first_r <= 1'b0;
    end else begin
      ph_r <= ph_nxt;
      start_seen_r <= start_tg_r;
      cnt_r <= cnt_nxt;
      sh_r <= start_pend ? {7'h00, sda_i} : byte_in;
      if (ph_r == tmas_pkg::PH_ADDR && last_bit) begin
        rw_r <= sda_i;
        ara_r <= addr_ara;
        first_r <= 1'b1;
      end
      if (ph_r == tmas_pkg::PH_ACKA) begin
        tx_r <= ara_r ? {DEV_ADDR, 1'b1} : rd_mux(ptr_r);
      end else if (ph_r == tmas_pkg::PH_RDAT) begin
        tx_r <= {tx_r[6:0], 1'b1};
      end
      if (reg_wr) begin
        first_r <= 1'b0;
        if (first_r) begin
          ptr_r <= byte_in;
        end
      end
    end
  end

  always_ff @(posedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      regs <= '{`TMAS_CFG_RST, `TMAS_HI_RST, `TMAS_LO_RST, `TMAS_HI_RST, `TMAS_LO_RST};
      ev_tg <= 3'h0;
    end else begin
      if (reg_wr && !first_r) begin
        ev_tg[0] <= ~ev_tg[0];
        case (ptr_r)
          `TMAS_WR_CFG: regs.cfg <= byte_in;
          `TMAS_WR_LHI: regs.lhi <= byte_in;
          `TMAS_WR_LLO: regs.llo <= byte_in;
          `TMAS_WR_RHI: regs.rhi <= byte_in;
          `TMAS_WR_RLO: regs.rlo <= byte_in;
          `TMAS_WR_ONESHOT: ev_tg[1] <= ~ev_tg[1];
          default: ;
        endcase
      end
      if (ph_r == tmas_pkg::PH_ACKR && ara_r && !start_pend) begin
        ev_tg[2] <= ~ev_tg[2];
      end
    end
  end

  // Data is driven on the falling clock edge.
  always_ff @(negedge scl_clk or negedge rst_n) begin
    if (!rst_n) begin
      sda_oe_r <= 1'b0;
    end else begin
      sda_oe_r <= drive;
    end
  end

  assign sda_oe = sda_oe_r;

  a_ara_reply: assert property (@(posedge scl_clk) disable iff (!rst_n)
    ph_r == tmas_pkg::PH_ACKA && ara_r && rw_r && !start_pend
    |=> ph_r == tmas_pkg::PH_RDAT && tx_r == {DEV_ADDR, 1'b1})
    else $error("alert reply byte wrong");

endmodule

`default_nettype wire

// ===== tb/tmas_host.sv
`timescale 1ns/1ps
`default_nettype none

// ====================================================================
// Bus master model; its clock stands high between frames.
module tmas_host (
  output logic scl_clk,
  output logic sda_pull,
  input wire logic sda
);
  initial begin
    scl_clk = 1'b1;
    sda_pull = 1'b0;
  end

  // One bit: data moves while the clock is low and is sampled midway through the high phase.
  task automatic bit_x(input logic b, output logic r);
    sda_pull = !b;
    #20 scl_clk = 1'b1;
    #20 r = sda;
    #20 scl_clk = 1'b0;
    #20;
  endtask

  // Eight bits, most significant first, then a released acknowledge slot.
  task automatic byte_x(input logic [7:0] d, output logic [7:0] q, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], q[i]);
    end
    bit_x(1'b1, r);
    ack = !r;
  endtask

  // Start and stop conditions; the data edge that marks each one moves while the clock is high.
  task automatic start_x();
    #40 sda_pull = 1'b1;
    #40 scl_clk = 1'b0;
    #20;
  endtask
  task automatic stop_x();
    sda_pull = 1'b1;
    #20 scl_clk = 1'b1;
    #20 sda_pull = 1'b0;
    #40;
  endtask

  // Write frame: pointer byte, then the data byte when asked for.
  task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d, input logic with_d,
                    output logic ack);
    logic [7:0] q;
    logic k;
    start_x();
    byte_x({a, 1'b0}, q, ack);
    byte_x(p, q, k);
    if (with_d) begin
      byte_x(d, q, k);
    end
    stop_x();
  endtask

  // Read frame of one byte; the byte is answered with not-acknowledge and a stop.
  task automatic rd(input logic [6:0] a, output logic [7:0] q, output logic ack);
    logic k;
    start_x();
    byte_x({a, 1'b1}, q, ack);
    byte_x(8'hFF, q, k);
    stop_x();
  endtask
endmodule

`default_nettype wire

// ===== tb/temp_monitor_alert_standby_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "tmas_regs.svh"

// ====================================================================
// Bench for the alert, standby and fault logic against an integer model.
module temp_monitor_alert_standby_bench;
  localparam int CC = 50;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic standby_pin_n_n = 1'b1;
  logic ropen = 1'b0;
  logic done = 1'b0;
  logic under = 1'b0;
  logic [7:0] loc = 8'h10;
  logic [10:0] rem = 11'h100;
  logic sda_o, sda_oe, alert_o, alert_oe, start, abort, scl, hpull;
  wire sda = !(sda_oe || hpull);
  int errors = 0;
  int samples_checked = 0;
  int starts = 0;
  int aborts = 0;
  int left = 0;
  int wait_n = 5;
  int m_lhi = 127;
  int m_llo = -128;
  int m_rlo = -128;
  int m_r;
  int n;
  logic [7:0] m_stat = 8'h00;
  logic m_alert = 1'b0;
  logic [31:0] seed;
  logic [7:0] q;
  logic ack;

  always #50 mclk = !mclk;

  tmas_top #(.CONV_CYC(CC)) i_tmas_top (.mclk(mclk), .rst_n(rst_n), .ce(1'b1), .scl_clk(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .alert_o(alert_o), .alert_oe(alert_oe), .standby_pin_n(standby_pin_n_n),
    .remote_open(ropen), .adc_done(done), .adc_local(loc), .adc_remote(rem), .adc_under(under),
    .adc_start(start), .adc_abort(abort));
  tmas_host i_tmas_host (.scl_clk(scl), .sda_pull(hpull), .sda(sda));

  // Converter model: answers each start after wait_n cycles unless aborted.
  always @(negedge mclk) begin
    done <= start !== 1'b1 && abort !== 1'b1 && left == 1;
    if (start === 1'b1) begin
      starts++;
      left = wait_n;
    end else if (abort === 1'b1) begin
      aborts++;
      left = 0;
    end else if (left == 1) begin
      left = 0;
    end else if (left > 1) begin
      left--;
    end
  end

  // Compare and count; a mismatch is reported at once.
  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Register access through the bus model; writes leave time to cross domains.
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_tmas_host.wr(`TMAS_DEV_ADDR, p, d, 1'b1, ack);
    chk(ack, 1'b1);
    repeat (4) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] exp);
    i_tmas_host.wr(`TMAS_DEV_ADDR, p, 8'h00, 1'b0, ack);
    i_tmas_host.rd(`TMAS_DEV_ADDR, q, ack);
    chk(ack, 1'b1);
    chk(q, exp);
    @(negedge mclk);
  endtask

  // Bounded wait for a new start, and optionally for its completion.
  task automatic wait_for(input int n0, input logic need_done);
    int k;
    k = 0;
    while ((starts == n0 || (need_done && done !== 1'b1)) && k < 300) begin
      @(negedge mclk);
      k++;
    end
    if (k == 300) chk(1'b0, 1'b1);
  endtask

  // New readings, then temperatures, status and the alert pin against the model.
  task automatic step(input logic [7:0] l, input logic [10:0] r);
    loc = l;
    rem = r;
    m_r = under ? -128 : int'($signed(r[10:3]));
    m_stat = {1'b0, $signed(l) > m_lhi, $signed(l) < m_llo, m_r > 127, m_r < m_rlo, ropen, 2'b00};
    m_alert = m_alert || (m_stat != 8'h00);
    repeat (3) @(negedge mclk);
    wait_for(starts, 1'b1);
    repeat (3) @(negedge mclk);
    rd(`TMAS_RD_LTEMP, l);
    rd(`TMAS_RD_RTEMP, m_r[7:0]);
    rd(`TMAS_RD_STAT, m_stat);
    chk(alert_oe, m_alert);
    chk(alert_o, 1'b0);
    chk(sda_o, 1'b0);
  endtask

  // Alert response read; the reply is checked and the alert model updated.
  task automatic ara();
    i_tmas_host.rd(`TMAS_ARA, q, ack);
    chk(ack, m_alert);
    if (m_alert) chk(q, {`TMAS_DEV_ADDR, 1'b1});
    m_alert = m_alert && (m_stat != 8'h00);
    repeat (4) @(negedge mclk);
    chk(alert_oe, m_alert);
  endtask

  // Counts conversion starts over a span, after an optional one-shot write.
  task automatic shot(input logic go, input int exp_n);
    n = starts;
    if (go) wr(`TMAS_WR_ONESHOT, 8'($random(seed)));
    repeat (CC + 30) @(negedge mclk);
    chk(11'(starts - n), 11'(exp_n));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence: free run, limits, alert procedure, faults, standby.
  initial begin
    seed = 32'hB788;
    repeat (8) @(negedge mclk);
    rst_n = 1'b1;
    rd(`TMAS_RD_LHI, 8'h7F);
    rd(`TMAS_RD_RLO, 8'h80);
    for (int i = 0; i < 3; i++) begin
      step(8'($random(seed)) & 8'h3F, 11'($random(seed)) & 11'h1FF);
    end
    step(8'h20, 11'h100);
    $display("test free_run done");
    wr(`TMAS_WR_LHI, 8'h30);
    m_lhi = 48;
    wr(`TMAS_WR_LLO, 8'h10);
    m_llo = 16;
    step(8'h30, 11'h100);
    step(8'h31, 11'h100);
    ara();
    step(8'h10, 11'h100);
    step(8'h0F, 11'h100);
    step(8'h20, 11'h100);
    ara();
    ara();
    $display("test limits done");
    ropen = 1'b1;
    step(8'h20, 11'h100);
    ropen = 1'b0;
    step(8'h20, 11'h100);
    ara();
    under = 1'b1;
    wr(`TMAS_WR_RLO, 8'h80);
    step(8'h20, 11'h7FF);
    under = 1'b0;
    $display("test faults done");
    wr(`TMAS_WR_CFG, 8'h40);
    rd(`TMAS_RD_CFG, 8'h40);
    shot(1'b0, 0);
    shot(1'b1, 1);
    standby_pin_n_n = 1'b0;
    shot(1'b1, 0);
    wr(`TMAS_WR_CFG, 8'h00);
    shot(1'b0, 0);
    wait_n = 40;
    n = starts;
    standby_pin_n_n = 1'b1;
    wait_for(n, 1'b0);
    n = aborts;
    loc = 8'h66;
    standby_pin_n_n = 1'b0;
    repeat (10) @(negedge mclk);
    chk(11'(aborts - n), 11'h001);
    rd(`TMAS_RD_LTEMP, 8'h20);
    $display("test standby done");
    summarize();
  end

  // Watchdog: far longer than the sequence needs.
  initial begin
    #4000000;
    errors++;
    summarize();
  end
endmodule

`default_nettype wire
